// [core/serial_buf_regs.vh]
`ifndef SERIAL_BUF_REGS_VH
`define SERIAL_BUF_REGS_VH
// ==========================================
// register offsets (byte address on the plain port)
`define OFF_STATUS      4'h0
`define OFF_DATA        4'h1
`define OFF_CTRL1       4'h2
`define OFF_CTRL2       4'h3
// ==========================================
// status field positions
`define ST_RX_FULL      7
`define ST_TX_EMPTY     5
`define ST_MODE_FAULT   4
// ==========================================
// control 1 field positions
`define C1_RX_IRQ_EN    7
`define C1_ENABLE       6
`define C1_TX_IRQ_EN    5
`define C1_MASTER       4
`define C1_SEL_OUT_EN   1
// control 2 field positions
`define C2_FAULT_EN     4
// ==========================================
// reset values
`define CTRL1_RST       8'h04
`define CTRL2_RST       8'h00
`define DATA_RST        8'h00
// ==========================================
// timing: shift clock half period, in ns and in cycles of 20 ns
`define HALF_BIT_NS     80
`define CLK_NS          20
`define HALF_BIT_CYC    (`HALF_BIT_NS / `CLK_NS)
`define BITS_PER_XFER   8
`endif

// [core/serial_shifter.v]
`timescale 1ns/1ps
`include "serial_buf_regs.vh"
// ==========================================
// eight bit shifter: master makes the clock, slave follows sync'd pins
module serial_shifter #(
    parameter HALF = `HALF_BIT_CYC
) (
    input  wire       clk_sys,
    input  wire       arst_n,
    input  wire       ce,
    input  wire       master,
    input  wire       load,
    input  wire [7:0] load_data,
    input  wire       sck_in,
    input  wire       miso_in,
    input  wire       mosi_in,
    input  wire       ss_in_n,
    output reg        busy_r,
    output reg        done_r,
    output reg  [7:0] rx_data_r,
    output reg        sck_out_r,
    output reg        sdo_r
);
    reg [7:0] sh_r;
    reg [3:0] bit_r;
    reg [7:0] div_r;
    reg       sck_d_r;
    wire      sdi = master ? miso_in : mosi_in;
    wire      rise = master ? (div_r == HALF - 1 && !sck_out_r) : (sck_in && !sck_d_r);
    wire      fall = master ? (div_r == HALF - 1 && sck_out_r) : (!sck_in && sck_d_r);

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_r    <= 1'b0;
            done_r    <= 1'b0;
            rx_data_r <= 8'h00;
            sck_out_r <= 1'b0;
            sdo_r     <= 1'b0;
            sh_r      <= 8'h00;
            bit_r     <= 4'h0;
            div_r     <= 8'h00;
            sck_d_r   <= 1'b0;
        end else if (ce) begin
            done_r  <= 1'b0;
            sck_d_r <= sck_in;
            if (load && !busy_r) begin
                busy_r <= 1'b1;
                sh_r   <= load_data;
                sdo_r  <= load_data[7];
                bit_r  <= 4'h0;
                div_r  <= 8'h00;
            end else if (busy_r) begin
                if (master)
                    div_r <= (div_r == HALF - 1) ? 8'h00 : div_r + 8'h01;
                if (master && div_r == HALF - 1)
                    sck_out_r <= ~sck_out_r;
                if (!master && ss_in_n) begin
                    busy_r <= 1'b0;
                end else if (rise) begin
                    sh_r  <= {sh_r[6:0], sdi};
                    bit_r <= bit_r + 4'h1;
                    if (bit_r == `BITS_PER_XFER - 1) begin
                        done_r    <= 1'b1;
                        rx_data_r <= {sh_r[6:0], sdi};
                    end
                end else if (fall) begin
                    sdo_r <= sh_r[7];
                    // busy holds through the trailing fall so the clock idles low
                    if (bit_r == `BITS_PER_XFER)
                        busy_r <= 1'b0;
                end
            end
        end
    end
endmodule

// [core/serial_buf.v]
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "serial_buf_regs.vh"
// Operation
// - transfer end sets receive full flag
// - status read then data read clears
// - transmit empty high while buffer free
// - armed status read then data write clears
// - unarmed data write is discarded
// - transmit empty and enable raise irq
// - buffer-to-shifter move sets transmit empty
// - idle write reaches shifter within two cycles
// - shift end loads queued byte
// - no queued byte means no move
// - master with select low sets fault
// - fault only when master, enabled, no output
// - armed status read then control 1 write clears fault
// - unused status bits zero, writes ignored
// - data reads receive buffer, writes transmit
// - master write starts a transfer
// - overrun keeps old byte, drops new
// - no overrun indication given
// - receive enable with full or fault irq
module serial_buf (
    input  wire       clk_sys,
    input  wire       arst_n,
    input  wire       ce,
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata_r,
    input  wire       sck_pin,
    input  wire       miso_pin,
    input  wire       mosi_pin,
    input  wire       ss_pin_n,
    output reg        sck_out_r,
    output reg        sck_oe_r,
    output reg        mosi_out_r,
    output reg        mosi_oe_r,
    output reg        miso_out_r,
    output reg        miso_oe_r,
    output reg        ss_out_n_r,
    output reg        ss_oe_r,
    output reg        irq_r
);
    // ==========================================
    // pin synchronisers, first stage read only by second
    reg [3:0] sync1_r;
    reg [3:0] sync2_r;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 4'hF;
            sync2_r <= 4'hF;
        end else if (ce) begin
            sync1_r <= {ss_pin_n, mosi_pin, miso_pin, sck_pin};
            sync2_r <= sync1_r;
        end
    end
    wire sck_s  = sync2_r[0];
    wire miso_s = sync2_r[1];
    wire mosi_s = sync2_r[2];
    wire ss_s_n = sync2_r[3];

    // ==========================================
    // control registers
    reg [7:0] ctrl1_r;
    reg [7:0] ctrl2_r;
    wire      master      = ctrl1_r[`C1_MASTER];
    wire      enable      = ctrl1_r[`C1_ENABLE];
    wire      fault_en    = ctrl2_r[`C2_FAULT_EN];
    wire      sel_out_en  = ctrl1_r[`C1_SEL_OUT_EN];

    // ==========================================
    // flags and buffers
    reg       rx_full_r;
    reg       tx_empty_r;
    reg       fault_r;
    reg       arm_rx_r;
    reg       arm_tx_r;
    reg       arm_fault_r;
    reg [7:0] rx_buf_r;
    reg [7:0] tx_buf_r;
    reg       tx_queued_r;
    reg       fault_in_d_r;

    wire      sh_busy;
    wire      sh_done;
    wire [7:0] sh_rx;
    wire      sh_sck;
    wire      sh_sdo;

    wire st_rd   = rd && addr == `OFF_STATUS;
    wire dat_rd  = rd && addr == `OFF_DATA;
    wire dat_wr  = wr && addr == `OFF_DATA;
    wire c1_wr   = wr && addr == `OFF_CTRL1;
    wire c2_wr   = wr && addr == `OFF_CTRL2;
    wire wr_ok   = dat_wr && arm_tx_r;
    // slave and master alike load a queued byte as soon as the shifter is idle and enabled
    wire do_load = tx_queued_r && !sh_busy && enable;
    wire fault_mode = master && fault_en && !sel_out_en;
    wire fault_set  = enable && fault_mode && !ss_s_n;

    serial_shifter #(
        .HALF (`HALF_BIT_CYC)
    ) u_shift (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .ce        (ce),
        .master    (master),
        .load      (do_load),
        .load_data (tx_buf_r),
        .sck_in    (sck_s),
        .miso_in   (miso_s),
        .mosi_in   (mosi_s),
        .ss_in_n   (ss_s_n),
        .busy_r    (sh_busy),
        .done_r    (sh_done),
        .rx_data_r (sh_rx),
        .sck_out_r (sh_sck),
        .sdo_r     (sh_sdo)
    );

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1_r      <= `CTRL1_RST;
            ctrl2_r      <= `CTRL2_RST;
            rx_full_r    <= 1'b0;
            tx_empty_r   <= 1'b1;
            fault_r      <= 1'b0;
            arm_rx_r     <= 1'b0;
            arm_tx_r     <= 1'b0;
            arm_fault_r  <= 1'b0;
            rx_buf_r     <= `DATA_RST;
            tx_buf_r     <= `DATA_RST;
            tx_queued_r  <= 1'b0;
            fault_in_d_r <= 1'b0;
        end else if (ce) begin
            fault_in_d_r <= fault_set;
            if (c1_wr)
                ctrl1_r <= wdata;
            if (c2_wr)
                ctrl2_r <= wdata;
            // arming follows only flags seen set by a status read
            if (st_rd) begin
                arm_rx_r    <= rx_full_r;
                arm_tx_r    <= tx_empty_r;
                arm_fault_r <= fault_r;
            end
            // receive side: set wins over clear
            if (sh_done && !rx_full_r) begin
                rx_buf_r  <= sh_rx;
                rx_full_r <= 1'b1;
            end else if (sh_done && rx_full_r && !(dat_rd && arm_rx_r)) begin
                rx_full_r <= 1'b1;
            end else if (sh_done) begin
                rx_buf_r  <= sh_rx;
                rx_full_r <= 1'b1;
            end else if (dat_rd && arm_rx_r) begin
                rx_full_r <= 1'b0;
            end
            if (dat_rd)
                arm_rx_r <= 1'b0;
            // transmit side
            if (wr_ok) begin
                tx_buf_r    <= wdata;
                tx_queued_r <= 1'b1;
                tx_empty_r  <= 1'b0;
                arm_tx_r    <= 1'b0;
            end else if (do_load) begin
                tx_queued_r <= 1'b0;
                tx_empty_r  <= 1'b1;
            end
            if (dat_wr && !arm_tx_r)
                arm_tx_r <= 1'b0;
            // mode fault: set wins over clear
            if (fault_set) begin
                fault_r <= 1'b1;
            end else if (c1_wr && arm_fault_r) begin
                fault_r <= 1'b0;
            end
            if (c1_wr)
                arm_fault_r <= 1'b0;
            // a fault drops master mode so the bus is released, unless control 1 is written in the fault's first cycle
            if (fault_set && !fault_in_d_r && !c1_wr)
                ctrl1_r[`C1_MASTER] <= 1'b0;
        end
    end

    // ==========================================
    // read data and pins, all registered
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r    <= 8'h00;
            sck_out_r  <= 1'b0;
            sck_oe_r   <= 1'b0;
            mosi_out_r <= 1'b0;
            mosi_oe_r  <= 1'b0;
            miso_out_r <= 1'b0;
            miso_oe_r  <= 1'b0;
            ss_out_n_r <= 1'b1;
            ss_oe_r    <= 1'b0;
            irq_r      <= 1'b0;
        end else if (ce) begin
            rdata_r <= 8'h00;
            if (rd) begin
                case (addr)
                    `OFF_STATUS: rdata_r <= {rx_full_r, 1'b0, tx_empty_r, fault_r, 4'h0};
                    `OFF_DATA:   rdata_r <= rx_buf_r;
                    `OFF_CTRL1:  rdata_r <= ctrl1_r;
                    `OFF_CTRL2:  rdata_r <= ctrl2_r;
                    default:     rdata_r <= 8'h00;
                endcase
            end
            irq_r <= (tx_empty_r && ctrl1_r[`C1_TX_IRQ_EN])
                  || ((rx_full_r || fault_r) && ctrl1_r[`C1_RX_IRQ_EN]);
            sck_out_r  <= sh_sck;
            sck_oe_r   <= enable && master;
            mosi_out_r <= sh_sdo;
            mosi_oe_r  <= enable && master;
            miso_out_r <= sh_sdo;
            miso_oe_r  <= enable && !master && !ss_s_n;
            ss_out_n_r <= !(sh_busy && master);
            ss_oe_r    <= enable && master && fault_en && sel_out_en;
        end
    end
endmodule

// [bench/serial_buf_sva.sv]
`timescale 1ns/1ps
// ========================================
// port checks; mirrors track what software did
module serial_buf_sva (
    input wire       clk_sys,
    input wire       arst_n,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata_r,
    input wire       sck_out_r,
    input wire       mosi_out_r,
    input wire       irq_r
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    reg  [7:0] c1_r;
    reg        st_q_r;
    reg        arm_r;
    reg  [3:0] quiet_r;
    reg  [4:0] wgap_r;
    wire       dwr  = wr & (addr == 4'h1);
    wire       arm  = arm_r | (st_q_r & rdata_r[5]);
    // idle needs a quiet line, an empty buffer alone is not enough
    // a start in flight has not toggled the clock yet, so the last accepted write counts too
    wire       idle = (quiet_r == 4'hF) & (wgap_r == 5'h1F) & c1_r[6] & c1_r[4];
    wire       ien  = c1_r[7] | c1_r[5];
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            c1_r    <= 8'h04;
            st_q_r  <= 1'b0;
            arm_r   <= 1'b0;
            quiet_r <= 4'hF;
            wgap_r  <= 5'h1F;
        end else begin
            if (dwr && arm) begin
                wgap_r <= 5'h00;
            end else if (wgap_r != 5'h1F) begin
                wgap_r <= wgap_r + 5'h01;
            end
            if (wr && addr == 4'h2) begin
                c1_r <= wdata;
            end
            st_q_r <= rd & (addr == 4'h0);
            arm_r  <= arm & ~dwr;
            if ($changed(sck_out_r)) begin
                quiet_r <= 4'h0;
            end else if (quiet_r != 4'hF) begin
                quiet_r <= quiet_r + 4'h1;
            end
        end
    end
    property p_spare; rd && addr == 4'h0 |=> rdata_r[6] == 1'b0 && rdata_r[3:0] == 4'h0; endproperty
    a_spare: assert property (p_spare) else $error("spare bits set");
    property p_unmap; rd && addr > 4'h3 |=> rdata_r == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_quiet; !$past(rd) |-> rdata_r == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("read data outside slot");
    property p_half; $rose(sck_out_r) |-> sck_out_r [*4] ##1 !sck_out_r; endproperty
    a_half: assert property (p_half) else $error("clock high phase");
    property p_hold; sck_out_r && $past(sck_out_r) |-> $stable(mosi_out_r); endproperty
    a_hold: assert property (p_hold) else $error("data moved while clock high");
    property p_start; dwr && arm && idle |-> ##[1:20] $rose(sck_out_r); endproperty
    a_start: assert property (p_start) else $error("no transfer start");
    property p_drop; dwr && !arm && idle |-> !sck_out_r [*8]; endproperty
    a_drop: assert property (p_drop) else $error("unarmed write sent");
    property p_irq; irq_r |-> ien || $past(ien); endproperty
    a_irq: assert property (p_irq) else $error("irq without enable");
endmodule

// [bench/spi_slave_model.sv]
`timescale 1ns/1ps
// ========================================
// far-side slave, mode 0, msb first; frame k sends tx_byte + k
module spi_slave_model (
    input  wire       sck,
    input  wire       mosi,
    input  wire [7:0] tx_byte,
    output wire       miso,
    output reg  [7:0] rx_byte,
    output reg  [7:0] frames
);
    reg [7:0] sh_r = 8'h00;
    reg [3:0] n_r = 4'h0;
    initial rx_byte = 8'h00;
    initial frames = 8'h00;
    assign miso = sh_r[7];
    always @(tx_byte) if (n_r == 4'h0) sh_r = tx_byte + frames;
    always @(posedge sck) begin
        rx_byte = {rx_byte[6:0], mosi};
        n_r = n_r + 4'h1;
    end
    // reload on the trailing edge so the next msb is ready early
    always @(negedge sck) begin
        if (n_r == 4'h8) begin
            frames = frames + 8'h01;
            n_r = 4'h0;
            sh_r = tx_byte + frames;
        end else begin
            sh_r = {sh_r[6:0], 1'b0};
        end
    end
endmodule

// [bench/serial_buf_tb.sv]
`timescale 1ns/1ps
// ========================================
// bench
module serial_buf_tb;
    reg        clk_sys = 1'b0;
    reg        arst_n = 1'b0;
    reg  [3:0] addr = 4'h0;
    reg  [7:0] wdata = 8'h00;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    reg        ss_pin_n = 1'b1;
    reg  [7:0] tx_byte = 8'h00;
    wire [7:0] rdata_r;
    wire       sck_out_r;
    wire       mosi_out_r;
    wire       miso_pin;
    wire       irq_r;
    wire [7:0] rx_byte;
    wire [7:0] frames;
    integer    error_cnt = 0;
    integer    checks = 0;
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    serial_buf dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata_r(rdata_r), .sck_pin(1'b0), .miso_pin(miso_pin),
        .mosi_pin(1'b0), .ss_pin_n(ss_pin_n), .sck_out_r(sck_out_r), .sck_oe_r(),
        .mosi_out_r(mosi_out_r), .mosi_oe_r(), .miso_out_r(), .miso_oe_r(),
        .ss_out_n_r(), .ss_oe_r(), .irq_r(irq_r));
    spi_slave_model slv (.sck(sck_out_r), .mosi(mosi_out_r), .tx_byte(tx_byte),
        .miso(miso_pin), .rx_byte(rx_byte), .frames(frames));
    task end_of_test;
        begin
            $display("errors %0d checks %0d", error_cnt, checks);
            if (error_cnt == 0 && checks > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wreg(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk_sys);
            wr <= 1'b0;
        end
    endtask
    task rchk(input [3:0] a, input [7:0] e);
        begin
            @(posedge clk_sys);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk_sys);
            rd <= 1'b0;
            #1 cmp(rdata_r, e);
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wait_frames(input [7:0] t);
        integer k;
        begin
            for (k = 0; k < 400 && frames !== t; k = k + 1) @(posedge clk_sys);
            if (frames !== t) begin
                error_cnt = error_cnt + 1;
                end_of_test;
            end
            idle(30);
        end
    endtask
    task fault_case(input [7:0] c1, input [7:0] c2, input [7:0] e);
        begin
            wreg(4'h3, c2);
            wreg(4'h2, c1);
            ss_pin_n <= 1'b0;
            idle(8);
            ss_pin_n <= 1'b1;
            idle(4);
            cmp({7'h00, irq_r}, {7'h00, e[4]});
            rchk(4'h0, e);
            wreg(4'h2, 8'hD0);
            rchk(4'h0, 8'h20);
        end
    endtask
    initial begin
        idle(6);
        arst_n <= 1'b1;
        rchk(4'h0, 8'h20);
        wreg(4'h0, 8'hFF);
        rchk(4'h0, 8'h20);
        rchk(4'hF, 8'h00);
        wreg(4'h2, 8'h70);
        idle(3);
        cmp({7'h00, irq_r}, 8'h01);
        wreg(4'h2, 8'h50);
        idle(3);
        cmp({7'h00, irq_r}, 8'h00);
        tx_byte <= 8'hC3;
        rchk(4'h0, 8'h20);
        wreg(4'h1, 8'hA5);
        wreg(4'h1, 8'h3C);
        rchk(4'h0, 8'h20);
        wait_frames(8'h01);
        cmp(rx_byte, 8'hA5);
        rchk(4'h1, 8'hC3);
        rchk(4'h0, 8'hA0);
        rchk(4'h1, 8'hC3);
        rchk(4'h0, 8'h20);
        idle(60);
        cmp(frames, 8'h01);
        rchk(4'h0, 8'h20);
        tx_byte <= 8'h5A;
        rchk(4'h0, 8'h20);
        wreg(4'h1, 8'h11);
        rchk(4'h0, 8'h20);
        wreg(4'h1, 8'h22);
        rchk(4'h0, 8'h00);
        wait_frames(8'h03);
        cmp(rx_byte, 8'h22);
        rchk(4'h0, 8'hA0);
        rchk(4'h1, 8'h5B);
        fault_case(8'hD0, 8'h00, 8'h20);
        fault_case(8'hD2, 8'h10, 8'h20);
        fault_case(8'hD0, 8'h10, 8'h30);
        end_of_test;
    end
endmodule
bind serial_buf serial_buf_sva chk (.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .sck_out_r(sck_out_r),
    .mosi_out_r(mosi_out_r), .irq_r(irq_r));
